// [bmd_pkg.sv]
// Shared constants and types for the bank-mode / operation-class decoder.
// Assumes 18-bit words with bit 17 as the leading (sign) bit.
package bmd_pkg;
  // Word and address geometry
  localparam int WORD_W = 18;
  localparam int PC_W = 15;
  localparam int BANK_W = 13;
  localparam int PAGE_W = 12;
  localparam int SIGN_BIT = 17;
  localparam int OP_LSB = 14;
  localparam int IND_BIT = 13;
  localparam int IDX_BIT = 12;

  // Class codes, matched on the leading bits of the word
  localparam logic [4:0] OPR_CODE = 5'h1E;
  localparam logic [5:0] IDX_CODE = 6'h3A;
  localparam logic [3:0] EAE_CODE = 4'hD;
  localparam logic [3:0] NONMEM_OP = 4'hD;

  // Operate microinstruction bit positions
  localparam int MI_CMA = 0;
  localparam int MI_CML = 1;
  localparam int MI_HALT = 2;
  localparam int MI_SMA = 3;
  localparam int MI_SZA = 4;
  localparam int MI_SNL = 5;
  localparam int MI_INV = 6;
  localparam int MI_CLL = 7;
  localparam int MI_RAR = 8;
  localparam int MI_RAL = 9;
  localparam int MI_CLA = 10;
  localparam int MI_TWO = 11;
  localparam int MI_IAC = 12;

  // I/O transfer fields
  localparam int IOT_DEV_LSB = 6;
  localparam int IOT_DEV_W = 6;
  localparam int IOT_SUB_LSB = 4;
  localparam int IOT_IN_BIT = 3;
  localparam int IOT_PULSE_LSB = 0;
  localparam int IOT_PULSES = 3;

  // Index operate functions
  localparam int IX_FN_LSB = 9;
  localparam int IX_N_W = 8;
  localparam logic [2:0] IX_CLX = 3'h0;
  localparam logic [2:0] IX_CLLR = 3'h1;
  localparam logic [2:0] IX_PAX = 3'h2;
  localparam logic [2:0] IX_PAL = 3'h3;
  localparam logic [2:0] IX_PXA = 3'h4;
  localparam logic [2:0] IX_PLA = 3'h5;
  localparam logic [2:0] IX_AXR = 3'h6;
  localparam logic [2:0] IX_AXS = 3'h7;

  // Arithmetic path selections
  localparam logic [2:0] ALU_ONES = 3'h0;
  localparam logic [2:0] ALU_TWOS = 3'h1;
  localparam logic [2:0] ALU_AND = 3'h2;
  localparam logic [2:0] ALU_XOR = 3'h3;
  localparam logic [2:0] ALU_NEG = 3'h4;

  // Register byte offsets
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_PC = 8'h04;
  localparam logic [7:0] ADR_AC = 8'h08;
  localparam logic [7:0] ADR_LINK = 8'h0C;
  localparam logic [7:0] ADR_INDEX = 8'h10;
  localparam logic [7:0] ADR_LIMIT = 8'h14;
  localparam logic [7:0] ADR_INDPTR = 8'h18;
  localparam logic [7:0] ADR_MEM = 8'h1C;
  localparam logic [7:0] ADR_ALU = 8'h20;
  localparam logic [7:0] ADR_STATUS = 8'h24;
  localparam logic [7:0] ADR_EA = 8'h28;
  localparam logic [7:0] ADR_DP_HI = 8'h30;
  localparam logic [7:0] ADR_DP_LO = 8'h34;
  localparam logic [7:0] ADR_DPS_HI = 8'h38;
  localparam logic [7:0] ADR_DPS_LO = 8'h3C;

  // Status register fields
  localparam int ST_BANK = 0;
  localparam int ST_HALT = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_SKIP = 3;
  localparam int ST_CLS_LSB = 4;
  localparam int ST_EM_LSB = 7;

  // Reset values and bus answers
  localparam logic [17:0] RST_WORD = 18'h00000;
  localparam logic [14:0] RST_PC = 15'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    CL_MEMREF, CL_IOT, CL_OPR, CL_IDX, CL_EAE, CL_BANK_ON, CL_BANK_OFF, CL_RSVD
  } bmd_class_e;

  typedef enum logic [1:0] {IO_IDLE, IO_P1, IO_P2, IO_P3} bmd_iot_e;
endpackage : bmd_pkg

// [bmd_arith.sv]
// Combinational data path: complement adds, Boolean ops, double-precision sum.
// Assumes operands come from flops in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module bmd_arith #(
  parameter int W = bmd_pkg::WORD_W
) (
  // Single-precision operands and selection
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic [2:0] op,
  output logic [W-1:0] result,
  // Double precision: high word holds sign and upper bits
  input wire logic [W-1:0] dp_hi,
  input wire logic [W-1:0] dp_lo,
  output logic [W-1:0] dps_hi,
  output logic [W-1:0] dps_lo
);
  logic [W:0] raw_sum;
  logic [W-1:0] ones_sum;
  logic [W-1:0] negated;
  logic [2*W-1:0] dp_total;

  if (W < 2) begin : g_chk
    $error("bmd_arith: W must be at least 2");
  end

  assign raw_sum = {1'b0, a} + {1'b0, b};
  // End-around carry for ones complement; twos complement drops it
  assign ones_sum = raw_sum[W-1:0] + {{(W-1){1'b0}}, raw_sum[W]}; // [RULE18]
  assign negated = ~a + {{(W-1){1'b0}}, 1'b1}; // [RULE17]
  assign dp_total = {dp_hi, dp_lo} + {a, b}; // [RULE19]
  assign dps_hi = dp_total[2*W-1:W];
  assign dps_lo = dp_total[W-1:0];

  always_comb begin
    unique case (op)
      bmd_pkg::ALU_ONES: result = ones_sum; // [RULE18]
      bmd_pkg::ALU_TWOS: result = raw_sum[W-1:0]; // [RULE18]
      bmd_pkg::ALU_AND: result = a & b; // [RULE20]
      bmd_pkg::ALU_XOR: result = a ^ b; // [RULE20]
      bmd_pkg::ALU_NEG: result = negated;
      default: result = a;
    endcase
  end
endmodule : bmd_arith
`default_nettype wire

// [bmd_decode.sv]
// Instruction-class decoder with bank/page addressing, reached over AXI4-Lite.
// Assumes one clock; io_data_in comes from device pins and is resynchronised.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] Mode field: direct, indexed, indirect, indirect-indexed
// [RULE2] Opcode is leading four bits, address trailing twelve
// [RULE3] Bank mode uses index bit as address bit
// [RULE4] Bank mode suppresses all index operations
// [RULE5] Indirect addressing still works in bank mode
// [RULE6] Bank mode PC counts low 13 bits only
// [RULE7] Enter instruction sets bank, exit clears it
// [RULE8] I/O transfer issues device and subdevice codes
// [RULE9] Three separately enabled I/O strobe pulses
// [RULE10] Out puts accumulator on bus, in loads it
// [RULE11] Opcode 74 octal is microcoded operate
// [RULE12] Operate bits all act in one cycle
// [RULE13] Software avoids conflicting operate bit combinations
// [RULE14] Opcode 72 octal is index operate
// [RULE15] Opcode 64 octal goes to extended arithmetic
// [RULE16] Eighteen-bit words, leading bit is sign
// [RULE17] Twos complement: invert then add one
// [RULE18] Ones add wraps carry, twos add drops it
// [RULE19] Double precision: high word then low word
// [RULE20] AND and XOR on full unsigned words
// [RULE21] One bank bit, consulted every instruction, reset clears
module bmd_decode #(
  parameter int ADDR_W = 8,
  parameter logic [17:0] ENTER_CODE = 18'h3BFFE,
  parameter logic [17:0] EXIT_CODE = 18'h3BFFD,
  parameter logic [5:0] IOT_CODE = 6'h38
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // I/O bus
  output logic [5:0] io_dev_sel,
  output logic [1:0] io_subdev,
  output logic [2:0] io_strobe_pulse,
  output logic io_select,
  output logic io_out_xfer,
  output logic [17:0] io_data_out,
  input wire logic [17:0] io_data_in,
  // Extended arithmetic unit
  output logic extended_arithmetic_unit_start,
  output logic [13:0] extended_arithmetic_unit_cmd,
  // Processor state
  output logic bank_mode,
  output logic halted
);
  localparam int W = bmd_pkg::WORD_W;
  localparam int PW = bmd_pkg::PC_W;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("bmd_decode: ADDR_W must lie in 8..32");
  end

  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, rd_word;
  logic [W-1:0] ac_reg, idx_reg, lim_reg, ind_ptr_reg, mem_reg, dp_hi_reg, dp_lo_reg;
  logic [W-1:0] instr_reg, io_in_s1_reg, io_in_s2_reg, alu_result, dps_hi, dps_lo;
  logic [PW-1:0] pc_reg, ea_reg;
  logic link_reg, bank_reg, halt_reg, skip_reg, io_in_dir_reg, eae_start_reg;
  logic [2:0] alu_op_reg, io_mask_reg;
  logic [5:0] io_dev_reg;
  logic [1:0] io_sub_reg, emode_reg;
  logic [13:0] eae_cmd_reg;
  bmd_pkg::bmd_class_e cls_reg, cls;
  bmd_pkg::bmd_iot_e io_state_reg;
  logic wr_fire, instr_fire, io_load;
  logic [31:0] wr_merged;
  logic [W-1:0] word, ac_x, idx_x, lim_x, nsx;
  logic [PW-1:0] pc_x, ea_x, base;
  logic link_x, bank_x, halt_x, skip_x, cond;
  logic [W:0] rot;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : wmerge

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      bmd_pkg::ADR_INSTR, bmd_pkg::ADR_PC, bmd_pkg::ADR_AC, bmd_pkg::ADR_LINK,
      bmd_pkg::ADR_INDEX, bmd_pkg::ADR_LIMIT, bmd_pkg::ADR_INDPTR, bmd_pkg::ADR_MEM,
      bmd_pkg::ADR_ALU, bmd_pkg::ADR_STATUS, bmd_pkg::ADR_EA, bmd_pkg::ADR_DP_HI,
      bmd_pkg::ADR_DP_LO, bmd_pkg::ADR_DPS_HI, bmd_pkg::ADR_DPS_LO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic bmd_pkg::bmd_class_e classify(input logic [17:0] w);
    if (w == ENTER_CODE) classify = bmd_pkg::CL_BANK_ON;
    else if (w == EXIT_CODE) classify = bmd_pkg::CL_BANK_OFF;
    else if (w[17:13] == bmd_pkg::OPR_CODE) classify = bmd_pkg::CL_OPR; // [RULE11]
    else if (w[17:12] == bmd_pkg::IDX_CODE) classify = bmd_pkg::CL_IDX; // [RULE14]
    else if (w[17:12] == IOT_CODE) classify = bmd_pkg::CL_IOT;
    else if (w[17:bmd_pkg::OP_LSB] == bmd_pkg::EAE_CODE) classify = bmd_pkg::CL_EAE; // [RULE15]
    else if (w[17:bmd_pkg::OP_LSB] < bmd_pkg::NONMEM_OP) classify = bmd_pkg::CL_MEMREF; // [RULE2]
    else classify = bmd_pkg::CL_RSVD;
  endfunction : classify

  function automatic logic [14:0] pc_step(input logic [14:0] pc, input logic bank, input logic skip);
    logic [14:0] inc;
    inc = skip ? 15'h0002 : 15'h0001;
    if (bank) pc_step = {pc[14:bmd_pkg::BANK_W], pc[12:0] + inc[12:0]}; // [RULE6]
    else pc_step = pc + inc;
  endfunction : pc_step

  // Bus write side: address and data may arrive in either order
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;
  assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_merged = wmerge({14'h0000, instr_reg}, w_data_reg, w_strb_reg);
  assign instr_fire = wr_fire & (aw_addr_reg == bmd_pkg::ADR_INSTR) & (io_state_reg == bmd_pkg::IO_IDLE) & ~halt_reg;
  assign io_load = (io_state_reg == bmd_pkg::IO_P3) & io_in_dir_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= bmd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? bmd_pkg::RESP_OKAY : bmd_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Instruction execution, all effects decided in one cycle
  always_comb begin
    word = wr_merged[W-1:0];
    cls = classify(word);
    ac_x = ac_reg;
    link_x = link_reg;
    idx_x = idx_reg;
    lim_x = lim_reg;
    bank_x = bank_reg;
    halt_x = halt_reg;
    skip_x = 1'b0;
    ea_x = ea_reg;
    base = {pc_reg[PW-1:bmd_pkg::PAGE_W], word[11:0]};
    nsx = {{(W-bmd_pkg::IX_N_W){word[7]}}, word[7:0]};
    cond = 1'b0;
    rot = {link_reg, ac_reg};
    unique case (cls)
      bmd_pkg::CL_MEMREF: begin
        if (bank_reg) base = {pc_reg[PW-1:bmd_pkg::BANK_W], word[12:0]}; // [RULE3]
        if (word[bmd_pkg::IND_BIT]) base = ind_ptr_reg[PW-1:0]; // [RULE1] [RULE5]
        if (word[bmd_pkg::IDX_BIT] && !bank_reg) base = base + idx_reg[PW-1:0]; // [RULE1] [RULE4]
        ea_x = base;
      end
      bmd_pkg::CL_OPR: begin
        // Skip sensing looks at values from before any change
        cond = (word[bmd_pkg::MI_SMA] & ac_reg[bmd_pkg::SIGN_BIT]) | // [RULE16]
               (word[bmd_pkg::MI_SZA] & (ac_reg == bmd_pkg::RST_WORD)) |
               (word[bmd_pkg::MI_SNL] & link_reg);
        skip_x = cond ^ word[bmd_pkg::MI_INV]; // [RULE12]
        if (word[bmd_pkg::MI_CLA]) rot[W-1:0] = bmd_pkg::RST_WORD; // [RULE12]
        if (word[bmd_pkg::MI_CLL]) rot[W] = 1'b0;
        if (word[bmd_pkg::MI_CMA]) rot[W-1:0] = ~rot[W-1:0];
        if (word[bmd_pkg::MI_CML]) rot[W] = ~rot[W];
        if (word[bmd_pkg::MI_IAC]) rot[W-1:0] = rot[W-1:0] + {{(W-1){1'b0}}, 1'b1}; // [RULE17]
        for (int k = 0; k < 2; k++) begin
          if (k == 0 || word[bmd_pkg::MI_TWO]) begin
            if (word[bmd_pkg::MI_RAL]) rot = {rot[W-1:0], rot[W]};
            else if (word[bmd_pkg::MI_RAR]) rot = {rot[0], rot[W:1]};
          end
        end
        {link_x, ac_x} = rot;
        halt_x = halt_reg | word[bmd_pkg::MI_HALT];
      end
      bmd_pkg::CL_IDX: begin
        if (!bank_reg) begin // [RULE4]
          unique case (word[bmd_pkg::IX_FN_LSB +: 3])
            bmd_pkg::IX_CLX: idx_x = bmd_pkg::RST_WORD;
            bmd_pkg::IX_CLLR: lim_x = bmd_pkg::RST_WORD;
            bmd_pkg::IX_PAX: idx_x = ac_reg;
            bmd_pkg::IX_PAL: lim_x = ac_reg;
            bmd_pkg::IX_PXA: ac_x = idx_reg;
            bmd_pkg::IX_PLA: ac_x = lim_reg;
            bmd_pkg::IX_AXR: idx_x = idx_reg + nsx;
            bmd_pkg::IX_AXS: begin
              idx_x = idx_reg + nsx;
              skip_x = $signed(idx_x) >= $signed(lim_reg); // [RULE14]
            end
          endcase
        end
      end
      bmd_pkg::CL_BANK_ON: bank_x = 1'b1; // [RULE7]
      bmd_pkg::CL_BANK_OFF: bank_x = 1'b0; // [RULE7]
      default: begin
      end
    endcase
    pc_x = pc_step(pc_reg, bank_reg, skip_x); // [RULE21]
  end

  // Processor state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_reg <= 1'b0; // [RULE21]
      halt_reg <= 1'b0;
      pc_reg <= bmd_pkg::RST_PC;
      ea_reg <= bmd_pkg::RST_PC;
      skip_reg <= 1'b0;
      cls_reg <= bmd_pkg::CL_RSVD;
      emode_reg <= 2'h0;
      instr_reg <= bmd_pkg::RST_WORD;
    end else if (instr_fire) begin
      bank_reg <= bank_x; // [RULE7] [RULE21]
      halt_reg <= halt_x;
      pc_reg <= pc_x;
      ea_reg <= ea_x;
      skip_reg <= skip_x;
      cls_reg <= cls;
      emode_reg <= word[bmd_pkg::IDX_BIT +: 2]; // [RULE1]
      instr_reg <= word;
    end else if (wr_fire) begin
      if (aw_addr_reg == bmd_pkg::ADR_PC) pc_reg <= PW'(wmerge({17'h00000, pc_reg}, w_data_reg, w_strb_reg));
      // Halt is cleared by writing one to its status bit
      if (aw_addr_reg == bmd_pkg::ADR_STATUS && w_strb_reg[0] && w_data_reg[bmd_pkg::ST_HALT]) halt_reg <= 1'b0;
    end
  end

  // Accumulator, link, index and limit; an input transfer wins the accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_reg <= bmd_pkg::RST_WORD;
      link_reg <= 1'b0;
      idx_reg <= bmd_pkg::RST_WORD;
      lim_reg <= bmd_pkg::RST_WORD;
      ind_ptr_reg <= bmd_pkg::RST_WORD;
      mem_reg <= bmd_pkg::RST_WORD;
      dp_hi_reg <= bmd_pkg::RST_WORD;
      dp_lo_reg <= bmd_pkg::RST_WORD;
      alu_op_reg <= bmd_pkg::ALU_ONES;
    end else begin
      if (instr_fire) begin
        ac_reg <= ac_x;
        link_reg <= link_x;
        idx_reg <= idx_x;
        lim_reg <= lim_x;
      end else if (wr_fire) begin
        unique case (aw_addr_reg)
          bmd_pkg::ADR_AC: ac_reg <= W'(wmerge({14'h0000, ac_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_LINK: if (w_strb_reg[0]) link_reg <= w_data_reg[0];
          bmd_pkg::ADR_INDEX: idx_reg <= W'(wmerge({14'h0000, idx_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_LIMIT: lim_reg <= W'(wmerge({14'h0000, lim_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_INDPTR: ind_ptr_reg <= W'(wmerge({14'h0000, ind_ptr_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_MEM: mem_reg <= W'(wmerge({14'h0000, mem_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_DP_HI: dp_hi_reg <= W'(wmerge({14'h0000, dp_hi_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_DP_LO: dp_lo_reg <= W'(wmerge({14'h0000, dp_lo_reg}, w_data_reg, w_strb_reg));
          bmd_pkg::ADR_ALU: if (w_strb_reg[0]) begin
            alu_op_reg <= w_data_reg[2:0];
            ac_reg <= alu_result; // [RULE17] [RULE18] [RULE20]
          end
          default: begin
          end
        endcase
      end
      if (io_load) ac_reg <= io_in_s2_reg; // [RULE10]
    end
  end

  // The path result follows the operation being written, not the stored one
  bmd_arith #(.W(W)) u_arith (
    .a(ac_reg),
    .b(mem_reg),
    .op(w_data_reg[2:0]),
    .result(alu_result),
    .dp_hi(dp_hi_reg),
    .dp_lo(dp_lo_reg),
    .dps_hi(dps_hi),
    .dps_lo(dps_lo)
  );

  // Input data from pins passes two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_in_s1_reg <= bmd_pkg::RST_WORD;
      io_in_s2_reg <= bmd_pkg::RST_WORD;
    end else begin
      io_in_s1_reg <= io_data_in;
      io_in_s2_reg <= io_in_s1_reg;
    end
  end

  // I/O transfer: three event times, each strobe enabled by its own bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      io_state_reg <= bmd_pkg::IO_IDLE;
      io_dev_reg <= 6'h00;
      io_sub_reg <= 2'h0;
      io_mask_reg <= 3'h0;
      io_in_dir_reg <= 1'b0;
    end else begin
      unique case (io_state_reg)
        bmd_pkg::IO_IDLE: if (instr_fire && cls == bmd_pkg::CL_IOT) begin
          io_dev_reg <= word[bmd_pkg::IOT_DEV_LSB +: bmd_pkg::IOT_DEV_W]; // [RULE8]
          io_sub_reg <= word[bmd_pkg::IOT_SUB_LSB +: 2]; // [RULE8]
          io_mask_reg <= word[bmd_pkg::IOT_PULSE_LSB +: bmd_pkg::IOT_PULSES]; // [RULE9]
          io_in_dir_reg <= word[bmd_pkg::IOT_IN_BIT];
          io_state_reg <= bmd_pkg::IO_P1;
        end
        bmd_pkg::IO_P1: io_state_reg <= bmd_pkg::IO_P2;
        bmd_pkg::IO_P2: io_state_reg <= bmd_pkg::IO_P3;
        bmd_pkg::IO_P3: io_state_reg <= bmd_pkg::IO_IDLE;
      endcase
    end
  end

  assign io_strobe_pulse = {io_mask_reg[2] & (io_state_reg == bmd_pkg::IO_P3),
                            io_mask_reg[1] & (io_state_reg == bmd_pkg::IO_P2),
                            io_mask_reg[0] & (io_state_reg == bmd_pkg::IO_P1)}; // [RULE9]
  assign io_select = io_state_reg != bmd_pkg::IO_IDLE; // [RULE8]
  assign io_out_xfer = io_select & ~io_in_dir_reg; // [RULE10]
  assign io_data_out = ac_reg; // [RULE10]
  assign io_dev_sel = io_dev_reg;
  assign io_subdev = io_sub_reg;

  // Extended arithmetic hand-off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eae_start_reg <= 1'b0;
      eae_cmd_reg <= 14'h0000;
    end else begin
      eae_start_reg <= instr_fire && cls == bmd_pkg::CL_EAE; // [RULE15]
      if (instr_fire && cls == bmd_pkg::CL_EAE) eae_cmd_reg <= word[13:0];
    end
  end

  assign extended_arithmetic_unit_start = eae_start_reg;
  assign extended_arithmetic_unit_cmd = eae_cmd_reg;
  assign bank_mode = bank_reg;
  assign halted = halt_reg;

  // Read side
  always_comb begin
    rd_word = 32'h00000000;
    case (s_axi_araddr[7:0])
      bmd_pkg::ADR_INSTR: rd_word[W-1:0] = instr_reg;
      bmd_pkg::ADR_PC: rd_word[PW-1:0] = pc_reg;
      bmd_pkg::ADR_AC: rd_word[W-1:0] = ac_reg;
      bmd_pkg::ADR_LINK: rd_word[0] = link_reg;
      bmd_pkg::ADR_INDEX: rd_word[W-1:0] = idx_reg;
      bmd_pkg::ADR_LIMIT: rd_word[W-1:0] = lim_reg;
      bmd_pkg::ADR_INDPTR: rd_word[W-1:0] = ind_ptr_reg;
      bmd_pkg::ADR_MEM: rd_word[W-1:0] = mem_reg;
      bmd_pkg::ADR_ALU: rd_word[2:0] = alu_op_reg;
      bmd_pkg::ADR_STATUS: begin
        rd_word[bmd_pkg::ST_BANK] = bank_reg;
        rd_word[bmd_pkg::ST_HALT] = halt_reg;
        rd_word[bmd_pkg::ST_BUSY] = io_select;
        rd_word[bmd_pkg::ST_SKIP] = skip_reg;
        rd_word[bmd_pkg::ST_CLS_LSB +: 3] = cls_reg;
        rd_word[bmd_pkg::ST_EM_LSB +: 2] = emode_reg;
      end
      bmd_pkg::ADR_EA: rd_word[PW-1:0] = ea_reg;
      bmd_pkg::ADR_DP_HI: rd_word[W-1:0] = dp_hi_reg;
      bmd_pkg::ADR_DP_LO: rd_word[W-1:0] = dp_lo_reg;
      bmd_pkg::ADR_DPS_HI: rd_word[W-1:0] = dps_hi; // [RULE19]
      bmd_pkg::ADR_DPS_LO: rd_word[W-1:0] = dps_lo; // [RULE19]
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= bmd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= mapped(s_axi_araddr[7:0]) ? bmd_pkg::RESP_OKAY : bmd_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule : bmd_decode
`default_nettype wire

// [bmd_decode_asserts.sv]
// Checker for the decoder's I/O strobes and mode outputs.
// Assumes it is bound to bmd_decode and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bmd_decode_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched outputs
  input wire logic s_axi_bvalid,
  input wire logic [5:0] io_dev_sel,
  input wire logic [1:0] io_subdev,
  input wire logic [2:0] io_strobe_pulse,
  input wire logic io_select,
  input wire logic io_out_xfer,
  input wire logic extended_arithmetic_unit_start,
  input wire logic bank_mode,
  input wire logic halted
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pulse slots: bit0 in P1, bit1 in P2, bit2 in P3
  sequence pulse_order_s;
    io_strobe_pulse[2:1] == 2'h0 ##1 io_strobe_pulse[2] == 1'b0 && io_strobe_pulse[0] == 1'b0
      ##1 io_strobe_pulse[1:0] == 2'h0;
  endsequence
  sel_length_a: assert property ($rose(io_select) |-> io_select [*3] ##1 !io_select)
    else $error("select length");
  pulse_order_a: assert property ($rose(io_select) |-> pulse_order_s)
    else $error("pulse slot");
  pulse_sel_a: assert property (io_strobe_pulse != 3'h0 |-> io_select && $onehot(io_strobe_pulse))
    else $error("stray pulse");
  out_sel_a: assert property (io_out_xfer |-> io_select)
    else $error("out without select");
  dev_hold_a: assert property (io_select && $past(io_select) |-> $stable({io_dev_sel, io_subdev}))
    else $error("device code moved");
  eae_pulse_a: assert property (extended_arithmetic_unit_start |=> !extended_arithmetic_unit_start)
    else $error("start too long");
  bank_change_a: assert property ($changed(bank_mode) |-> $rose(s_axi_bvalid))
    else $error("bank changed alone");
  halt_change_a: assert property ($changed(halted) |-> $rose(s_axi_bvalid))
    else $error("halt changed alone");
endmodule : bmd_decode_asserts
bind bmd_decode bmd_decode_asserts u_chk (.*);
`default_nettype wire

// [bmd_io_dev.sv]
// I/O device model: answers in-transfers, captures out-transfers.
// Assumes select and direction come straight from the decoder.
`timescale 1ns/1ps
`default_nettype none
module bmd_io_dev #(
  parameter logic [17:0] WORD = 18'h2A5C3
) (
  // Clock and bus
  input wire logic aclk,
  input wire logic io_select,
  input wire logic io_out_xfer,
  input wire logic [17:0] io_data_out,
  output logic [17:0] io_data_in,
  output logic [17:0] got
);
  // Idle bus churns so a stale word never passes
  logic [17:0] idle_reg = 18'h15555;
  always_ff @(posedge aclk) begin
    idle_reg <= ~idle_reg;
    if (io_out_xfer) got <= io_data_out;
  end
  assign io_data_in = (io_select && !io_out_xfer) ? WORD : idle_reg;
endmodule : bmd_io_dev
`default_nettype wire

// [bank_mode_opclass_decode_tb.sv]
// Bench: register rows, then I/O, halt and reset cases.
// Assumes AXI4-Lite answers and a device model on the I/O bus.
`timescale 1ns/1ps
`default_nettype none
module bank_mode_opclass_decode_tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, io_strobe_pulse;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, io_subdev, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_select, io_out_xfer;
  logic extended_arithmetic_unit_start, bank_mode, halted;
  logic [5:0] io_dev_sel;
  logic [13:0] extended_arithmetic_unit_cmd;
  logic [17:0] io_data_out, io_data_in, got;
  int failures = 0, checked = 0, cyc = 0;
  // Row: write addr, write data, read addr, expected, bank
  localparam logic [59:0] ROWS [29] = '{
    60'h083FFFF083FFFF0, 60'h1C000011C000010, 60'h200000108000000,
    60'h083FFFF083FFFF0, 60'h200000008000010, 60'h080000F080000F0,
    60'h2000004083FFF10, 60'h1C3FFF01C3FFF00, 60'h2000002083FFF00,
    60'h200000308000000, 60'h1C000011C000010, 60'h343FFFF38000010,
    60'h30000023C000000, 60'h100000510000050, 60'h180555518055550,
    60'h000112328001280, 60'h003BFFE28001281, 60'h000112328011231,
    60'h000212328055551, 60'h0407FFF0407FFF1, 60'h003C01004060011,
    60'h003A40010000051, 60'h003BFFD04060030, 60'h0407FFF0407FFF0,
    60'h003C00004000000, 60'h003412304000010, 60'h003C401083FFFF0,
    60'h003A400103FFFF0, 60'hFC00000FC000000};
  always #2.5 aclk = ~aclk;
  bmd_decode dut (.*);
  bmd_io_dev dev (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk
  task finish_test;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(bank_mode, 32'h0);
    foreach (ROWS[i]) begin
      wr(ROWS[i][59:52], {12'h000, ROWS[i][51:32]});
      rd(ROWS[i][31:24]);
      chk(rdat, {12'h000, ROWS[i][23:4]});
      chk({s_axi_bresp, rsp}, (ROWS[i][31:24] == 8'hFC) ? 32'hF : 32'h0);
      chk(bank_mode, ROWS[i][3:0]);
    end
    chk(extended_arithmetic_unit_cmd, 32'h0123);
    wr(8'h00, 32'h38AB5);
    repeat (4) @(posedge aclk);
    chk({io_dev_sel, io_subdev}, 32'hAB);
    chk(got, 32'h3FFFF);
    // In-direction: device word lands in AC
    wr(8'h00, 32'h38ABF);
    repeat (4) @(posedge aclk);
    rd(8'h08);
    chk(rdat, 32'h2A5C3);
    wr(8'h00, 32'h3C004);
    chk(halted, 32'h1);
    wr(8'h00, 32'h3BFFE);
    wr(8'h24, 32'h2);
    chk({halted, bank_mode}, 32'h0);
    wr(8'h00, 32'h3BFFE);
    chk(bank_mode, 32'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(bank_mode, 32'h0);
    finish_test;
  end
endmodule : bank_mode_opclass_decode_tb
`default_nettype wire
